// ---- src/cvt_pkg.sv ----
/*
 * shared constants and carrier types of the crt video timing generator.
 * assumes a single 40 MHz system clock and a plain strobe register port.
 */
package cvt_pkg;
	localparam int unsigned CVT_AW = 4;
	localparam int unsigned CVT_DW = 16;
	localparam int unsigned CVT_HW = 12;
	localparam int unsigned CVT_VW = 12;
	localparam int unsigned CVT_RW = 9;
	// register offsets (word index)
	localparam logic [3:0] CVT_REG_HTOTAL = 4'h0;
	localparam logic [3:0] CVT_REG_HDISP = 4'h1;
	localparam logic [3:0] CVT_REG_HABB = 4'h2;
	localparam logic [3:0] CVT_REG_HABF = 4'h3;
	localparam logic [3:0] CVT_REG_HSB = 4'h4;
	localparam logic [3:0] CVT_REG_HSW = 4'h5;
	localparam logic [3:0] CVT_REG_VTOT = 4'h6;
	localparam logic [3:0] CVT_REG_VDISP = 4'h7;
	localparam logic [3:0] CVT_REG_VABB = 4'h8;
	localparam logic [3:0] CVT_REG_VABF = 4'h9;
	localparam logic [3:0] CVT_REG_VSB = 4'hA;
	localparam logic [3:0] CVT_REG_VSW = 4'hB;
	localparam logic [3:0] CVT_REG_DCTL = 4'hC;
	localparam logic [3:0] CVT_REG_EC1 = 4'hD;
	localparam logic [3:0] CVT_REG_STAT = 4'hE;
	localparam logic [3:0] CVT_REG_VERT_COUNTER = 4'hF;
	// display control fields
	localparam int unsigned CVT_DC_LAYOUT_LO = 1;
	localparam int unsigned CVT_DC_REPEAT = 3;
	localparam int unsigned CVT_DC_ILACE = 4;
	localparam int unsigned CVT_DC_ENABLE = 5;
	localparam int unsigned CVT_DC_HPOL = 6;
	localparam int unsigned CVT_DC_VPOL = 7;
	// extended config one: nugget divisor field
	localparam int unsigned CVT_EC1_DIV_LO = 11;
	// vertical value split
	localparam int unsigned CVT_ADJ_W = 3;
	localparam logic [15:0] CVT_RST_ZERO = 16'h0000;
	// status read-back bits
	localparam int unsigned CVT_ST_FIELD = 0;
	localparam int unsigned CVT_ST_VBLK = 1;
	localparam int unsigned CVT_ST_VSYNC = 2;
	localparam int unsigned CVT_ST_HBLK = 3;
	localparam logic [4:0] CVT_MOD_2 = 5'h02;
	localparam logic [4:0] CVT_MOD_4 = 5'h04;
	localparam logic [4:0] CVT_MOD_6 = 5'h06;
	localparam logic [4:0] CVT_MOD_8 = 5'h08;
	localparam logic [4:0] CVT_MOD_12 = 5'h0C;
	localparam logic [4:0] CVT_MOD_16 = 5'h10;
	localparam logic [1:0] CVT_XFER_DLY = 2'h2;

	typedef struct packed {
		logic [CVT_AW-1:0] addr;
		logic [CVT_DW-1:0] wdata;
		logic wr;
		logic rd;
	} cvt_bus_req_t;

	typedef struct packed {
		logic blank_n;
		logic alt_blank_n;
		logic hsync;
		logic vsync;
		logic xfer_req;
		logic refresh_req;
		logic [CVT_RW-1:0] refresh_row;
	} cvt_video_t;
endpackage : cvt_pkg

// ---- src/cvt_timing.sv ----
/*
 * crt video timing generator: registers, octet divider, horizontal and vertical counters,
 * blank, alternate blank, sync, transfer and refresh requests.
 * assumes the nugget clock arrives as a synchronous one-cycle enable on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module cvt_timing #(
	parameter int unsigned HW = 12,
	parameter int unsigned VW = 12
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic nugget_in_clock,
	input wire cvt_pkg::cvt_bus_req_t bus_req,
	output logic [cvt_pkg::CVT_DW-1:0] bus_rdata,
	output cvt_pkg::cvt_video_t video
);
	import cvt_pkg::*;

	typedef struct packed {
		logic [HW-1:0] h_total, horiz_display_end, h_ab_begin, h_ab_finish, h_sync_begin, h_sync_width;
		logic [VW-1:0] v_total, vertical_display_end, v_ab_begin, v_ab_finish, v_sync_begin, v_sync_width;
		logic [7:0] dctl;
		logic [2:0] ec1_div;
		logic [2:0] div_cnt;
		logic octet;
		logic [HW-1:0] horiz_counter;
		logic [VW-1:0] vert_counter;
		logic [HW-1:0] hsync_cnt;
		logic [VW-1:0] vsync_cnt;
		logic hblank, vblank_req, vblank;
		logic hab, vab_req, vab;
		logic hsync, vsync;
		logic [1:0] xfer_dly;
		logic xfer;
		logic refresh;
		logic [CVT_RW-1:0] refresh_row;
		logic field;
		logic [CVT_DW-1:0] rdata;
	} cvt_state_t;

	cvt_state_t s_q, s_d;

	// scan-line modulus from layout field and line repeat bit
	function automatic logic [4:0] line_modulus(input logic [1:0] layout, input logic rep);
		case ({layout, rep})
			3'b000: line_modulus = CVT_MOD_2;
			3'b010: line_modulus = CVT_MOD_4;
			3'b011: line_modulus = CVT_MOD_8;
			3'b100: line_modulus = CVT_MOD_6;
			3'b101: line_modulus = CVT_MOD_12;
			3'b110: line_modulus = CVT_MOD_8;
			3'b111: line_modulus = CVT_MOD_16;
			default: line_modulus = CVT_MOD_4; // illegal code, normal modulus
		endcase
	endfunction : line_modulus

	// compare point: base times modulus plus adjust plus one
	function automatic logic [VW:0] vert_point(input logic [VW-1:0] v, input logic [4:0] m);
		logic [VW+5:0] p;
		p = '0;
		p = (VW+6)'(v[VW-1:CVT_ADJ_W]) * (VW+6)'(m) + (VW+6)'(v[CVT_ADJ_W-1:0]) + (VW+6)'(1);
		if ({2'h0, v[CVT_ADJ_W-1:0]} > m) begin
			vert_point = {1'b1, {VW{1'b0}}}; // top bit marks disabled
		end else begin
			vert_point = {1'b0, p[VW-1:0]};
		end
	endfunction : vert_point

	// writable field at an address
	function automatic logic hit(input logic [3:0] a, input cvt_bus_req_t r);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	logic [4:0] modulus;
	logic [VW:0] vt_pt, vd_pt, vs_pt;
	logic enable, ilace, half_ev, full_ev, step_v, frame_end;
	logic [VW-1:0] vert_counter_next;
	logic [HW-1:0] horiz_counter_next;

	assign modulus = line_modulus(s_q.dctl[CVT_DC_LAYOUT_LO +: 2], s_q.dctl[CVT_DC_REPEAT]);
	assign vt_pt = vert_point(s_q.v_total, modulus);
	assign vd_pt = vert_point(s_q.vertical_display_end, modulus);
	assign vs_pt = vert_point(s_q.v_sync_begin, modulus);
	assign enable = s_q.dctl[CVT_DC_ENABLE];
	assign ilace = s_q.dctl[CVT_DC_ILACE];
	assign half_ev = s_q.octet && (s_q.horiz_counter == (s_q.h_total >> 1));
	assign full_ev = s_q.octet && (s_q.horiz_counter == s_q.h_total);
	assign step_v = full_ev || (half_ev && ilace);
	// last line of the frame is one below the effective total; a counter left beyond a
	// freshly shortened total also ends the frame instead of running to wrap-around
	assign frame_end = !vt_pt[VW] && (s_q.vert_counter >= vt_pt[VW-1:0] - VW'(1));
	assign vert_counter_next = frame_end ? '0 : s_q.vert_counter + VW'(1);
	assign horiz_counter_next = full_ev ? '0 : s_q.horiz_counter + HW'(1);

	// next-state logic
	always_comb begin
		s_d = s_q;
		s_d.octet = 1'b0;
		s_d.xfer = 1'b0;
		s_d.refresh = 1'b0;
		// register writes
		if (hit(CVT_REG_HTOTAL, bus_req)) s_d.h_total = bus_req.wdata[HW-1:0];
		if (hit(CVT_REG_HDISP, bus_req)) s_d.horiz_display_end = bus_req.wdata[HW-1:0];
		if (hit(CVT_REG_HABB, bus_req)) s_d.h_ab_begin = bus_req.wdata[HW-1:0];
		if (hit(CVT_REG_HABF, bus_req)) s_d.h_ab_finish = bus_req.wdata[HW-1:0];
		if (hit(CVT_REG_HSB, bus_req)) s_d.h_sync_begin = bus_req.wdata[HW-1:0];
		if (hit(CVT_REG_HSW, bus_req)) s_d.h_sync_width = bus_req.wdata[HW-1:0];
		if (hit(CVT_REG_VTOT, bus_req)) s_d.v_total = bus_req.wdata[VW-1:0];
		if (hit(CVT_REG_VDISP, bus_req)) s_d.vertical_display_end = bus_req.wdata[VW-1:0];
		if (hit(CVT_REG_VABB, bus_req)) s_d.v_ab_begin = bus_req.wdata[VW-1:0];
		if (hit(CVT_REG_VABF, bus_req)) s_d.v_ab_finish = bus_req.wdata[VW-1:0];
		if (hit(CVT_REG_VSB, bus_req)) s_d.v_sync_begin = bus_req.wdata[VW-1:0];
		if (hit(CVT_REG_VSW, bus_req)) s_d.v_sync_width = bus_req.wdata[VW-1:0];
		if (hit(CVT_REG_DCTL, bus_req)) s_d.dctl = bus_req.wdata[7:0];
		if (hit(CVT_REG_EC1, bus_req)) s_d.ec1_div = bus_req.wdata[CVT_EC1_DIV_LO +: 3];
		// read data, valid the cycle after the strobe
		s_d.rdata = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				CVT_REG_HTOTAL: s_d.rdata = CVT_DW'(s_q.h_total);
				CVT_REG_HDISP: s_d.rdata = CVT_DW'(s_q.horiz_display_end);
				CVT_REG_HABB: s_d.rdata = CVT_DW'(s_q.h_ab_begin);
				CVT_REG_HABF: s_d.rdata = CVT_DW'(s_q.h_ab_finish);
				CVT_REG_HSB: s_d.rdata = CVT_DW'(s_q.h_sync_begin);
				CVT_REG_HSW: s_d.rdata = CVT_DW'(s_q.h_sync_width);
				CVT_REG_VTOT: s_d.rdata = CVT_DW'(s_q.v_total);
				CVT_REG_VDISP: s_d.rdata = CVT_DW'(s_q.vertical_display_end);
				CVT_REG_VABB: s_d.rdata = CVT_DW'(s_q.v_ab_begin);
				CVT_REG_VABF: s_d.rdata = CVT_DW'(s_q.v_ab_finish);
				CVT_REG_VSB: s_d.rdata = CVT_DW'(s_q.v_sync_begin);
				CVT_REG_VSW: s_d.rdata = CVT_DW'(s_q.v_sync_width);
				CVT_REG_DCTL: s_d.rdata = CVT_DW'(s_q.dctl);
				CVT_REG_EC1: s_d.rdata = CVT_DW'({s_q.ec1_div, 11'h000});
				CVT_REG_STAT: s_d.rdata = CVT_DW'({s_q.hblank, s_q.vsync, s_q.vblank, s_q.field});
				CVT_REG_VERT_COUNTER: s_d.rdata = CVT_DW'(s_q.vert_counter);
				default: s_d.rdata = '0;
			endcase
		end
		if (!enable) begin
			// video held in reset
			s_d.div_cnt = '0;
			s_d.horiz_counter = '0;
			s_d.vert_counter = '0;
			s_d.hsync_cnt = '0;
			s_d.vsync_cnt = '0;
			s_d.refresh_row = '0;
			s_d.hblank = 1'b0;
			s_d.vblank_req = 1'b0;
			s_d.vblank = 1'b0;
			s_d.hab = 1'b0;
			s_d.vab_req = 1'b0;
			s_d.vab = 1'b0;
			s_d.hsync = 1'b0;
			s_d.vsync = 1'b0;
			s_d.xfer_dly = '0;
			s_d.field = 1'b0;
		end else begin
			// nugget prescaler makes the octet tick
			if (nugget_in_clock) begin
				if (s_q.div_cnt >= s_q.ec1_div) begin
					s_d.div_cnt = '0;
					s_d.octet = 1'b1;
				end else begin
					s_d.div_cnt = s_q.div_cnt + 3'h1;
				end
			end
			if (s_q.octet) begin
				// horizontal counter and events
				s_d.horiz_counter = horiz_counter_next;
				// blank is raised as the display-end octet appears, so it covers that octet
				if (horiz_counter_next == s_q.horiz_display_end) begin
					s_d.hblank = 1'b1;
					s_d.xfer_dly = CVT_XFER_DLY;
				end
				if (s_q.xfer_dly != '0) begin
					s_d.xfer_dly = s_q.xfer_dly - 2'h1;
					s_d.xfer = (s_q.xfer_dly == 2'h1);
				end
				if (s_q.horiz_counter == s_q.h_ab_begin) s_d.hab = 1'b1;
				if (s_q.horiz_counter == s_q.h_ab_finish) s_d.hab = 1'b0;
				// horizontal sync runs on its own width counter, any start octet
				if (s_q.horiz_counter == s_q.h_sync_begin) begin
					s_d.hsync = 1'b1;
					s_d.hsync_cnt = '0;
				end else if (s_q.hsync) begin
					s_d.hsync_cnt = s_q.hsync_cnt + HW'(1);
					if (s_q.hsync_cnt + HW'(1) >= s_q.h_sync_width) s_d.hsync = 1'b0;
				end
				if (half_ev || full_ev) begin
					s_d.refresh_row = s_q.refresh_row + CVT_RW'(1);
					s_d.refresh = 1'b1;
				end
				if (step_v) begin
					s_d.vert_counter = vert_counter_next;
					if (frame_end) begin
						s_d.vblank_req = 1'b0;
						s_d.field = ilace ? ~s_q.field : 1'b0;
					end
					if (!vd_pt[VW] && vert_counter_next == vd_pt[VW-1:0]) s_d.vblank_req = 1'b1;
					if (vert_counter_next == s_q.v_ab_begin) s_d.vab_req = 1'b1;
					if (vert_counter_next == s_q.v_ab_finish) s_d.vab_req = 1'b0;
					// vertical sync width counter, lines or half lines
					if (!vs_pt[VW] && vert_counter_next == vs_pt[VW-1:0]) begin
						s_d.vsync = 1'b1;
						s_d.vsync_cnt = '0;
					end else if (s_q.vsync) begin
						s_d.vsync_cnt = s_q.vsync_cnt + VW'(1);
						if (s_q.vsync_cnt + VW'(1) >= s_q.v_sync_width) s_d.vsync = 1'b0;
					end
				end
				if (full_ev) begin
					s_d.hblank = 1'b0;
					// requests applied only at line ends, makes even fields longer
					s_d.vblank = frame_end ? 1'b0 : (s_d.vblank_req);
					s_d.vab = s_d.vab_req;
				end
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign bus_rdata = s_q.rdata;
	assign video.blank_n = !(s_q.hblank || s_q.vblank);
	assign video.alt_blank_n = !(s_q.hab || s_q.vab);
	assign video.hsync = s_q.hsync ^ s_q.dctl[CVT_DC_HPOL];
	assign video.vsync = s_q.vsync ^ s_q.dctl[CVT_DC_VPOL];
	assign video.xfer_req = s_q.xfer;
	assign video.refresh_req = s_q.refresh;
	assign video.refresh_row = s_q.refresh_row;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_line_wrap_zero: assert property (full_ev && enable |=> s_q.horiz_counter == '0)
		else $error("line end did not clear horizontal counter");
	chk_xfer_two_oct: assert property (s_q.octet && enable && s_q.horiz_counter == s_q.horiz_display_end
		|-> ##[2:64] s_q.xfer)
		else $error("transfer request missing after blank start");
	chk_refresh_step: assert property (s_q.refresh |-> s_q.refresh_row == $past(s_q.refresh_row) + CVT_RW'(1))
		else $error("refresh row did not advance");
	chk_disabled_idle: assert property (!enable |=> !s_q.hsync && !s_q.vsync && s_q.horiz_counter == '0)
		else $error("disabled video not idle");
	chk_hblank_set: assert property (s_q.octet && enable && s_q.horiz_counter == s_q.horiz_display_end && !full_ev
		|=> s_q.hblank)
		else $error("horizontal blank not set at display end");
	chk_blank_or: assert property ((s_q.hblank || s_q.vblank) |-> !video.blank_n)
		else $error("blank output not ored");
	chk_vert_counter_frame: assert property (s_q.octet && enable && full_ev && frame_end |=> s_q.vert_counter == '0)
		else $error("frame end did not clear vertical counter");
	chk_vert_counter_hold: assert property (s_q.octet && enable && !step_v |=> $stable(s_q.vert_counter))
		else $error("vertical counter moved without a step");
	chk_polarity_map: assert property (video.hsync == (s_q.hsync ^ s_q.dctl[CVT_DC_HPOL]))
		else $error("horizontal sync polarity wrong");
	// horizontal blank drops with the line end
	chk_hblank_clear: assert property (full_ev && enable
		|=> !s_q.hblank)
		else $error("horizontal blank not cleared at line end");
	// vertical blank only moves at line ends
	chk_vblank_sync: assert property (enable && !full_ev
		|=> $stable(s_q.vblank))
		else $error("vertical blank changed inside a line");
	// vertical alternate blank only moves at line ends
	chk_vab_sync: assert property (enable && !full_ev
		|=> $stable(s_q.vab))
		else $error("vertical alternate blank changed inside a line");
	// line end applies the pending vertical blank request
	chk_vblank_apply: assert property (full_ev && enable && !frame_end
		|=> s_q.vblank == s_q.vblank_req)
		else $error("vertical blank request not applied");
	// line end applies the pending alternate blank request
	chk_vab_apply: assert property (full_ev && enable
		|=> s_q.vab == s_q.vab_req)
		else $error("vertical alternate blank request not applied");
	// horizontal alternate blank starts at its begin octet
	chk_hab_begin: assert property (s_q.octet && enable && s_q.horiz_counter == s_q.h_ab_begin
		&& s_q.horiz_counter != s_q.h_ab_finish |=> s_q.hab)
		else $error("horizontal alternate blank did not start");
	// horizontal alternate blank ends at its finish octet
	chk_hab_finish: assert property (s_q.octet && enable && s_q.horiz_counter == s_q.h_ab_finish
		|=> !s_q.hab)
		else $error("horizontal alternate blank did not end");
	// horizontal sync starts at its begin octet
	chk_hsync_begin: assert property (s_q.octet && enable && s_q.horiz_counter == s_q.h_sync_begin
		|=> s_q.hsync)
		else $error("horizontal sync did not start");
	// horizontal sync ends once the width is used up
	chk_hsync_width: assert property (s_q.octet && enable && s_q.hsync && s_q.horiz_counter != s_q.h_sync_begin
		&& s_q.hsync_cnt + HW'(1) >= s_q.h_sync_width |=> !s_q.hsync)
		else $error("horizontal sync too long");
	// vertical sync starts at its compare line
	chk_vsync_begin: assert property (enable && step_v && !vs_pt[VW] && vert_counter_next == vs_pt[VW-1:0]
		|=> s_q.vsync)
		else $error("vertical sync did not start");
	// a disabled sync start never raises vertical sync
	chk_vsync_off: assert property (enable && step_v && vs_pt[VW] && !s_q.vsync
		|=> !s_q.vsync)
		else $error("disabled vertical sync fired");
	// frame end clears vertical blank
	chk_vblank_end: assert property (full_ev && frame_end && enable
		|=> !s_q.vblank)
		else $error("vertical blank not ended at frame end");
	// interlaced frames alternate the field bit
	chk_field_toggle: assert property (enable && ilace && step_v && frame_end
		|=> s_q.field != $past(s_q.field))
		else $error("field did not alternate");
	// progressive frames keep the field bit low
	chk_field_flat: assert property (enable && !ilace && step_v && frame_end
		|=> !s_q.field)
		else $error("field set without interlace");
	// each vertical step inside the frame adds one
	chk_vert_counter_step: assert property (enable && step_v && !frame_end
		|=> s_q.vert_counter == $past(s_q.vert_counter) + VW'(1))
		else $error("vertical counter did not step");
	// half line requests a refresh
	chk_half_refresh: assert property (half_ev && enable
		|=> s_q.refresh)
		else $error("no refresh at half line");
	// full line requests a refresh
	chk_full_refresh: assert property (full_ev && enable
		|=> s_q.refresh)
		else $error("no refresh at line end");
	// transfer request comes only out of the two-octet delay
	chk_xfer_source: assert property (s_q.xfer
		|-> $past(s_q.xfer_dly) == 2'h1)
		else $error("transfer request without delay");
	// prescaler holds the octet tick back until the divisor is reached
	chk_div_count: assert property (enable && nugget_in_clock && s_q.div_cnt < s_q.ec1_div
		|=> !s_q.octet)
		else $error("octet tick came early");
	// disabled video keeps row and pulses idle
	chk_idle_pulses: assert property (!enable
		|=> s_q.refresh_row == '0 && !s_q.xfer && !s_q.refresh)
		else $error("disabled video still requesting");
	// disabled video keeps both blank outputs released
	chk_idle_blank: assert property (!enable
		|=> video.blank_n && video.alt_blank_n)
		else $error("disabled video still blanking");
	// read data stands only after a read strobe
	chk_rdata_idle: assert property (!bus_req.rd
		|=> bus_rdata == '0)
		else $error("read data outside read cycle");
	cov_xfer: cover property (s_q.xfer);
	cov_field: cover property (ilace && step_v && frame_end);
	cov_hsync_wrap: cover property (s_q.hsync && s_q.horiz_counter == '0);
	cov_vsync: cover property (s_q.vsync && ilace);
	cov_frame: cover property (frame_end && full_ev);
endmodule : cvt_timing
`default_nettype wire

// ---- verif/cvt_crt_monitor.sv ----
/*
 * crt monitor model: counts blank, sync and request activity and times the syncs.
 * assumes video outputs are settled at each rising edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cvt_crt_monitor (
	input wire logic sys_clk,
	input wire cvt_pkg::cvt_video_t video,
	input wire logic hpol,
	input wire logic vpol,
	output var int n_blk,
	output var int n_ab,
	output var int n_hs,
	output var int n_vs,
	output var int n_ref,
	output var int h_per,
	output var int v_per,
	output var int xfer_gap
);
	import cvt_pkg::*;
	logic hs;
	logic vs;
	logic hs_q;
	logic vs_q;
	logic blk_q;
	int cyc = 0;
	int t_hs = 0;
	int t_vs = 0;
	int t_blk = 0;
	// syncs seen at the monitor's active level
	assign hs = video.hsync ^ hpol;
	assign vs = video.vsync ^ vpol;
	// start all tallies at zero
	initial begin
		{n_blk, n_ab, n_hs, n_vs, n_ref, h_per, v_per, xfer_gap} = '0;
	end
	// tally levels and pulses, time the leading sync edges
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		hs_q <= hs;
		vs_q <= vs;
		blk_q <= video.blank_n;
		n_blk <= n_blk + int'(!video.blank_n);
		n_ab <= n_ab + int'(!video.alt_blank_n);
		n_hs <= n_hs + int'(hs);
		n_vs <= n_vs + int'(vs);
		n_ref <= n_ref + int'(video.refresh_req);
		if (hs && !hs_q) begin
			h_per <= cyc - t_hs;
			t_hs <= cyc;
		end
		if (vs && !vs_q) begin
			v_per <= cyc - t_vs;
			t_vs <= cyc;
		end
		if (!video.blank_n && blk_q) begin
			t_blk <= cyc;
		end
		if (video.xfer_req) begin
			xfer_gap <= cyc - t_blk;
		end
	end
endmodule : cvt_crt_monitor
`default_nettype wire

// ---- verif/tb_crt_video_timing_generator.sv ----
/*
 * testbench of the crt video timing generator: programs the registers and judges the video outputs.
 * assumes a 40 MHz sys_clk and a nugget enable held high, so one octet per nugget with divisor 0.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_crt_video_timing_generator;
	import cvt_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic nugget_in_clock = 1'b1;
	cvt_bus_req_t bus_req = '0;
	logic [CVT_DW-1:0] bus_rdata;
	cvt_video_t video;
	int errors = 0;
	int cmp_count = 0;
	int n_blk, n_ab, n_hs, n_vs, n_ref, h_per, v_per, xfer_gap;
	int d_blk, d_ab, d_hs, d_vs, d_ref;
	logic [15:0] rd_val;
	logic [CVT_RW-1:0] row0;
	logic [4:0] mods [8] = '{CVT_MOD_2, CVT_MOD_4, CVT_MOD_4, CVT_MOD_8, CVT_MOD_6, CVT_MOD_12, CVT_MOD_8, CVT_MOD_16};
	// 25 ns clock
	always #12.5 sys_clk = ~sys_clk;
	cvt_timing u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .nugget_in_clock(nugget_in_clock), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .video(video));
	cvt_crt_monitor u_mon (.sys_clk(sys_clk), .video(video), .hpol(1'b1), .vpol(1'b0), .n_blk(n_blk), .n_ab(n_ab),
		.n_hs(n_hs), .n_vs(n_vs), .n_ref(n_ref), .h_per(h_per), .v_per(v_per), .xfer_gap(xfer_gap));
	task automatic conclude;
		$display("comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		rd_val = bus_rdata;
	endtask : rd
	// tally differences over n cycles
	task automatic win(input int n);
		int b, a, h, v, r;
		b = n_blk;
		a = n_ab;
		h = n_hs;
		v = n_vs;
		r = n_ref;
		repeat (n) @(posedge sys_clk);
		d_blk = n_blk - b;
		d_ab = n_ab - a;
		d_hs = n_hs - h;
		d_vs = n_vs - v;
		d_ref = n_ref - r;
	endtask : win
	function automatic logic [15:0] dc(input logic [1:0] lay, input logic rep, input logic il);
		dc = 16'h0060 | (16'(lay) << CVT_DC_LAYOUT_LO) | (16'(rep) << CVT_DC_REPEAT) | (16'(il) << CVT_DC_ILACE);
	endfunction : dc
	// 20-octet line: blank from 12, alt blank 10..16, sync at 14 for 3
	task automatic prog(input logic [15:0] dctl, vtot, vdisp, sync_begin_base, vsw);
		wr(CVT_REG_HTOTAL, 16'h0013);
		wr(CVT_REG_HDISP, 16'h000C);
		wr(CVT_REG_HABB, 16'h000A);
		wr(CVT_REG_HABF, 16'h0010);
		wr(CVT_REG_HSB, 16'h000E);
		wr(CVT_REG_HSW, 16'h0003);
		wr(CVT_REG_VTOT, vtot);
		wr(CVT_REG_VDISP, vdisp);
		wr(CVT_REG_VABB, 16'h0FFF);
		wr(CVT_REG_VABF, 16'h0000);
		wr(CVT_REG_VSB, sync_begin_base);
		wr(CVT_REG_VSW, vsw);
		wr(CVT_REG_EC1, 16'h0000);
		wr(CVT_REG_DCTL, dctl);
		repeat (800) @(posedge sys_clk);
	endtask : prog
	task automatic t_reset;
		@(posedge sys_clk);
		#1;
		check(video, 32'h0000_6000);
		wr(CVT_REG_HTOTAL, 16'h0013);
		rd(CVT_REG_HTOTAL);
		check(rd_val, 32'h0000_0013);
		@(posedge sys_clk);
		#1;
		check(bus_rdata, 32'h0000_0000);
		for (int p = 0; p < 4; p++) begin
			wr(CVT_REG_DCTL, 16'(p) << CVT_DC_HPOL);
			repeat (2) @(posedge sys_clk);
			#1;
			check({video.vsync, video.hsync}, 32'(p));
		end
	endtask : t_reset
	task automatic t_horiz;
		prog(dc(2'h0, 1'b0, 1'b0), 16'h0019, 16'h0007, 16'h0008, 16'h0002);
		win(20);
		check(d_blk, 32'h8);
		check(d_ab, 32'h6);
		check(d_hs, 32'h3);
		check(h_per, 32'h14);
		check(xfer_gap, 32'h2);
		row0 = video.refresh_row;
		win(100);
		check(d_ref, 32'hA);
		check(9'(video.refresh_row - row0), 32'hA);
		wr(CVT_REG_HSB, 16'h0012);
		repeat (60) @(posedge sys_clk);
		win(20);
		check(d_hs, 32'h3);
		check(h_per, 32'h14);
		wr(CVT_REG_EC1, 16'h0800);
		repeat (100) @(posedge sys_clk);
		win(40);
		check(h_per, 32'h28);
		check(d_hs, 32'h6);
	endtask : t_horiz
	task automatic t_vert;
		prog(dc(2'h0, 1'b0, 1'b0), 16'h0019, 16'h0011, 16'h0008, 16'h0002);
		win(160);
		check(v_per, 32'hA0);
		check(d_blk, 32'h58);
		check(d_vs, 32'h28);
		check(d_ab, 32'h30);
		rd(CVT_REG_VERT_COUNTER);
		check(rd_val < 16'h0008, 32'h1);
	endtask : t_vert
	task automatic t_mod;
		for (int i = 0; i < 8; i++) begin
			prog(dc(2'(i >> 1), i[0], 1'b0), 16'h0008, 16'h0007, 16'h0000, 16'h0001);
			check(v_per, 32'(mods[i] + 1) * 20);
		end
	endtask : t_mod
	task automatic t_ilace;
		prog(dc(2'h0, 1'b0, 1'b1), 16'h0010, 16'h0007, 16'h0000, 16'h0002);
		win(50);
		check(v_per, 32'h32);
		check(d_vs, 32'h14);
		win(100);
		check(d_ref, 32'hA);
	endtask : t_ilace
	task automatic t_adj_off;
		prog(dc(2'h0, 1'b0, 1'b0), 16'h0019, 16'h0007, 16'h0003, 16'h0002);
		win(400);
		check(d_vs, 32'h0);
		wr(CVT_REG_DCTL, 16'h0040);
		repeat (3) @(posedge sys_clk);
		#1;
		check(video, 32'h0000_7000);
		rd(CVT_REG_VERT_COUNTER);
		check(rd_val, 32'h0000_0000);
		win(100);
		check(d_ref, 32'h0);
	endtask : t_adj_off
	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_horiz;
		t_vert;
		t_mod;
		t_ilace;
		t_adj_off;
		conclude;
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		conclude;
	end
endmodule : tb_crt_video_timing_generator
`default_nettype wire
